// *** hw/fci_pkg.sv ***
// Constants for the flash command host controller
// Assumes one 25 MHz clock and an asynchronous x16 flash on plain pins
package fci_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_STROBE_NS   = 70;
  localparam int STROBE_CYC    = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);

  // ==========================================================
  // Flash command codes (low byte carries the code)
  localparam logic [15:0] CMD_READ_ARRAY  = 16'h00FF;
  localparam logic [15:0] CMD_PROG_SETUP  = 16'h0040;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
  localparam logic [15:0] CMD_CONFIRM     = 16'h00D0;
  localparam logic [15:0] CMD_SUSPEND     = 16'h00B0;
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [15:0] CMD_CLEAR_STAT  = 16'h0050;

  // ==========================================================
  // Flash status bits
  localparam int SR_READY      = 7;
  localparam int SR_ERASE_SUSP = 6;

  // ==========================================================
  // Controller register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int ST_BUSY    = 0;
  localparam int ST_ARRAY   = 1;
  localparam int ST_ERASING = 2;
  localparam int ST_SUSP    = 3;
  localparam int ST_REFUSED = 4;

  // ==========================================================
  // Operations written to CTRL[2:0]
  typedef enum logic [2:0] {
    OP_WRITE, OP_READ, OP_ARRAY_READ, OP_PROGRAM,
    OP_ERASE, OP_SUSPEND, OP_RESUME, OP_POLL
  } fci_op_e;

endpackage

// *** hw/fci_host.sv ***
// Host controller that drives an asynchronous flash through its command pins
// Assumes flash inputs are synchronous to CLK and software on AHB-Lite
//
// Added by the designer: the address map and the AHB-Lite slave port.
module fci_host #(
  parameter int ADDR_W    = 22,
  parameter int BLK_SHIFT = 15
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // Flash pins
  output logic      [ADDR_W-1:0] FL_ADDR,
  input  wire logic [15:0]       FL_DQ_IN,
  output logic      [15:0]       FL_DQ_OUT,
  output logic                   FL_DQ_OE,
  output logic                   FL_CE_N,
  output logic                   FL_OE_N,
  output logic                   FL_WE_N,
  output logic                   FL_RP_N
);
  import fci_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} fci_state_e;

  fci_state_e            state;
  fci_state_e            next_state;
  fci_op_e               op;
  logic [1:0]            step;
  logic [3:0]            cnt;
  logic [ADDR_W-1:0]     addr_reg;
  logic [15:0]           wdata_reg;
  logic [15:0]           rdata_reg;
  logic                  array_mode;
  logic                  erase_active;
  logic                  erase_susp;
  logic                  prog_susp;
  logic                  refused;
  logic [ADDR_W-1:BLK_SHIFT] susp_block;
  logic                  cyc_write;
  logic [15:0]           cyc_data;
  logic                  last_step;
  logic                  poll_again;
  logic                  hold_ce;
  logic                  ph_valid;
  logic                  ph_write;
  logic [7:0]            ph_addr;
  logic                  wr_ctrl;
  logic                  start;
  logic                  refuse;
  logic                  clr_refused;

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end else if (HREADY) begin
      ph_valid <= HSEL && HTRANS[1];
      ph_write <= HWRITE;
      ph_addr  <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      unique case (HADDR[7:0])
        REG_CTRL:   HRDATA <= {29'h0000_0000, op};
        REG_ADDR:   HRDATA <= 32'(addr_reg);
        REG_WDATA:  HRDATA <= {16'h0000, wdata_reg};
        REG_RDATA:  HRDATA <= {16'h0000, rdata_reg};
        REG_STATUS: HRDATA <= {27'h000_0000, refused, erase_susp, erase_active, array_mode,
                               state != S_IDLE};
        default:    HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  assign wr_ctrl     = ph_valid && ph_write && ph_addr == REG_CTRL;
  assign clr_refused = ph_valid && ph_write && ph_addr == REG_STATUS && HWDATA[ST_REFUSED];
  assign refuse      = wr_ctrl && state == S_IDLE && erase_susp
                       && (fci_op_e'(HWDATA[2:0]) == OP_PROGRAM || fci_op_e'(HWDATA[2:0]) == OP_ARRAY_READ)
                       && addr_reg[ADDR_W-1:BLK_SHIFT] == susp_block;
  assign start       = wr_ctrl && state == S_IDLE && !refuse;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_reg  <= '0;
      wdata_reg <= 16'h0000;
    end else if (ph_valid && ph_write && state == S_IDLE) begin
      if (ph_addr == REG_ADDR) addr_reg <= HWDATA[ADDR_W-1:0];
      if (ph_addr == REG_WDATA) wdata_reg <= HWDATA[15:0];
    end
  end

  // Refused flag: a new refusal wins over a clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      refused <= 1'b0;
    end else if (refuse) begin
      refused <= 1'b1;
    end else if (clr_refused) begin
      refused <= 1'b0;
    end
  end

  // ==========================================================
  // Command sequences: one bus cycle per step, except that OP_POLL repeats its status read step until the ready bit is set
  always_comb begin
    cyc_write = 1'b1;
    cyc_data  = wdata_reg;
    last_step = 1'b1;
    unique case (op)
      OP_WRITE: ;
      OP_READ:  cyc_write = 1'b0;
      OP_ARRAY_READ: begin
        last_step = step == 2'd1;
        if (step == 2'd0) cyc_data = CMD_READ_ARRAY;
        else cyc_write = 1'b0;
      end
      OP_PROGRAM: begin
        last_step = step == 2'd1;
        if (step == 2'd0) cyc_data = CMD_PROG_SETUP;
      end
      OP_ERASE: begin
        last_step = step == 2'd1;
        cyc_data  = (step == 2'd0) ? CMD_ERASE_SETUP : CMD_CONFIRM;
      end
      OP_SUSPEND: cyc_data = CMD_SUSPEND;
      OP_RESUME:  cyc_data = CMD_CONFIRM;
      OP_POLL: begin
        last_step = step == 2'd2;
        if (step == 2'd0) cyc_data = CMD_READ_STATUS;
        else if (step == 2'd1) cyc_write = 1'b0;
        else cyc_data = CMD_CLEAR_STAT;
      end
    endcase
  end

  assign poll_again = op == OP_POLL && step == 2'd1 && !rdata_reg[SR_READY];
  assign hold_ce    = (erase_active && !erase_susp)
                      || (state == S_HOLD && op == OP_ERASE && last_step)
                      || (state == S_HOLD && op == OP_RESUME && erase_susp && !prog_susp);

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE:   if (start) next_state = S_SETUP;
      S_SETUP:  next_state = S_STROBE;
      S_STROBE: if (cnt == STROBE_LAST) next_state = S_HOLD;
      S_HOLD:   next_state = (last_step && !poll_again) ? S_IDLE : S_SETUP;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_IDLE;
      cnt   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= (state == S_STROBE) ? cnt + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      op   <= OP_WRITE;
      step <= 2'd0;
    end else if (start) begin
      op   <= fci_op_e'(HWDATA[2:0]);
      step <= (fci_op_e'(HWDATA[2:0]) == OP_ARRAY_READ && array_mode) ? 2'd1 : 2'd0;
    end else if (state == S_HOLD && !last_step && !poll_again) begin
      step <= step + 2'd1;
    end
  end

  // Read data taken at the end of the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 16'h0000;
    end else if (state == S_STROBE && cnt == STROBE_LAST && !cyc_write) begin
      rdata_reg <= FL_DQ_IN;
    end
  end

  // ==========================================================
  // Tracking of the flash mode and of erase suspend
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      array_mode   <= 1'b0;
      erase_active <= 1'b0;
      erase_susp   <= 1'b0;
      prog_susp    <= 1'b0;
      susp_block   <= '0;
    end else if (state == S_HOLD && cyc_write) begin
      array_mode <= !hold_ce && !(op == OP_PROGRAM && last_step) && cyc_data[7:0] == CMD_READ_ARRAY[7:0];
      if (op == OP_ERASE && last_step) begin
        erase_active <= 1'b1;
        susp_block   <= addr_reg[ADDR_W-1:BLK_SHIFT];
      end
      if (op == OP_SUSPEND && erase_active) erase_susp <= 1'b1;
      if (op == OP_SUSPEND && erase_susp) prog_susp <= 1'b1;
      if (op == OP_RESUME) prog_susp <= 1'b0;
      if (op == OP_RESUME && !prog_susp) erase_susp <= 1'b0;
    end else if (state == S_HOLD && op == OP_POLL && rdata_reg[SR_READY] && !erase_susp) begin
      erase_active <= erase_active && rdata_reg[SR_ERASE_SUSP];
    end
  end

  // ==========================================================
  // Flash pin drive, all from flip-flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FL_CE_N   <= 1'b1;
      FL_OE_N   <= 1'b1;
      FL_WE_N   <= 1'b1;
      FL_DQ_OE  <= 1'b0;
      FL_RP_N   <= 1'b0;
      FL_ADDR   <= '0;
      FL_DQ_OUT <= 16'h0000;
    end else begin
      FL_RP_N  <= 1'b1;
      FL_CE_N  <= !(next_state != S_IDLE || hold_ce);
      FL_OE_N  <= !(next_state == S_STROBE && !cyc_write);
      FL_WE_N  <= !(next_state == S_STROBE && cyc_write);
      FL_DQ_OE <= (next_state == S_STROBE || next_state == S_HOLD) && cyc_write;
      if (start) FL_ADDR <= addr_reg;
      if (state == S_SETUP) FL_DQ_OUT <= cyc_data;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence erase_setup_write;
    state == S_HOLD && op == OP_ERASE && step == 2'd0;
  endsequence
  sequence confirm_strobe;
    FL_WE_N ##1 (!FL_WE_N && FL_DQ_OUT[7:0] == CMD_CONFIRM[7:0]);
  endsequence

  a_erase_confirm_follows: assert property (erase_setup_write |=> ##[0:2] confirm_strobe)
    else $error("erase setup not followed by confirm");

  a_ce_held_resumed: assert property (erase_active && !erase_susp && state == S_IDLE |=> !FL_CE_N)
    else $error("chip enable released during erase");

  a_refuse_block: assert property (refuse |=> refused && state == S_IDLE)
    else $error("program or read to suspended block not refused");

  a_array_before_read: assert property (op == OP_ARRAY_READ && !FL_OE_N |-> array_mode)
    else $error("array read without read-array mode");

  sequence poll_done;
    state == S_HOLD && op == OP_POLL && step == 2'd1 && rdata_reg[SR_READY];
  endsequence
  a_poll_then_clear: assert property (poll_done |=> ##[1:3] (!FL_WE_N && FL_DQ_OUT[7:0] == CMD_CLEAR_STAT[7:0]))
    else $error("status read not followed by clear");

  a_strobe_width: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*2] ##1 FL_WE_N)
    else $error("write strobe width wrong");

endmodule

// *** sim/fci_flash_model.sv ***
// Behavioural model of the asynchronous flash behind the command host controller
// Assumes strobes come from a controller clocked by clk; erase time counts clk cycles
module fci_flash_model #(
  parameter int          BLK_SHIFT = 15,
  parameter int          ERASE_CYC = 200,
  parameter int          PROG_CYC  = 40,
  parameter logic [15:0] ID_WORD   = 16'hA5C3, // Arbitrary identifier value
  parameter logic [15:0] QRY_WORD  = 16'h3C5A
) (
  // Clock
  input  wire logic        clk,
  // Flash pins
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rp_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // State
  logic [15:0]  mem [int];
  logic [1:0]   mode = 2'h0; // 0 array, 1 status, 2 identifier, 3 query
  logic [1:0]   pend = 2'h0; // 0 none, 1 program, 2 erase, 3 lock
  logic [1:0]   p;
  logic         e_run = 1'b0, e_susp = 1'b0, f_erase = 1'b0, f_prog = 1'b0;
  logic         p_run = 1'b0, p_susp = 1'b0;
  logic [127:0] lk = '0, dn = '0;
  logic [15:0]  rd_val = 16'h0000, held = 16'h0000;
  logic [7:0]   sr, c;
  int           e_cnt, e_blk, ai, blk, p_cnt;

  assign sr  = {!((e_run && !e_susp) || (p_run && !p_susp)), e_susp, f_erase, f_prog, 1'b0, p_susp, 2'h0};
  assign c   = dq_in[7:0];
  assign ai  = int'(addr);
  assign blk = int'(addr >> BLK_SHIFT);

  // ==========================================================
  // Reads: data latched at the falling strobe, inverse of last value when released
  always @(negedge oe_n or negedge ce_n) begin
    case (mode)
      2'h0: rd_val = mem.exists(ai) ? mem[ai] : 16'hFFFF;
      2'h1: rd_val = {8'h00, sr};
      2'h2: rd_val = (addr[1:0] == 2'h2) ? {14'h0000, dn[blk], lk[blk]} : ID_WORD;
      default: rd_val = QRY_WORD;
    endcase
  end
  always @(posedge oe_n) held <= rd_val;
  assign dq_out = (!ce_n && !oe_n) ? rd_val : ~held;

  // ==========================================================
  // Erase engine runs only while chip enable is low
  always @(posedge clk) begin
    if (!rp_n) begin
      e_run <= 1'b0;
      e_susp <= 1'b0;
    end else if (e_run && !e_susp && !ce_n) begin
      if (e_cnt == 0) begin
        foreach (mem[k]) if ((k >> BLK_SHIFT) == e_blk) mem[k] = 16'hFFFF;
        e_run <= 1'b0;
      end else e_cnt <= e_cnt - 1;
    end
  end

  // Program engine counts clk until done, standing still while suspended
  always @(posedge clk) begin
    if (p_run && !p_susp) begin
      if (p_cnt == 0) p_run <= 1'b0;
      else p_cnt <= p_cnt - 1;
    end
  end

  // ==========================================================
  // Command decoder
  always @(posedge we_n) begin
    if (!ce_n) begin
      p = pend;
      pend = 2'h0;
      if (p == 2'h1) begin
        mem[ai] = (mem.exists(ai) ? mem[ai] : 16'hFFFF) & dq_in;
        p_run = 1'b1;
        p_cnt = PROG_CYC;
        mode = 2'h1;
      end else if (p == 2'h2) begin
        if (c == 8'hD0) begin
          e_run = 1'b1;
          e_cnt = ERASE_CYC;
          e_blk = blk;
        end else {f_erase, f_prog} = 2'h3;
        mode = 2'h1;
      end else if (p == 2'h3) begin
        if (c == 8'h01) lk[blk] = 1'b1;
        if (c == 8'h2F) {dn[blk], lk[blk]} = 2'h3;
        if (c == 8'hD0 && !dn[blk]) lk[blk] = 1'b0;
      end else if ((e_run && !e_susp) || (p_run && !p_susp)) begin
        if (c == 8'h70) mode = 2'h1;
        if (c == 8'hB0 && p_run) p_susp = 1'b1;
        else if (c == 8'hB0) e_susp = 1'b1;
      end else begin
        case (c)
          8'hFF: mode = 2'h0;
          8'h90: mode = 2'h2;
          8'h98: mode = 2'h3;
          8'h70: mode = 2'h1;
          8'h50: {f_erase, f_prog} = 2'h0;
          8'h40, 8'h10: pend = 2'h1;
          8'h20: pend = e_susp ? 2'h0 : 2'h2;
          8'h60: pend = 2'h3;
          8'hD0: begin
            if (p_susp) p_susp = 1'b0;
            else e_susp = 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// *** sim/flash_command_interface_bench.sv ***
// Self-checking bench for the flash command host controller
// Assumes the design package, the controller and the flash model are compiled first
module flash_command_interface_bench import fci_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ID_WORD  = 16'hA5C3; // Arbitrary identifier value
  localparam logic [15:0] QRY_WORD = 16'h3C5A;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, dq_oe, ce_n, oe_n, we_n, rp_n;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [21:0] fl_addr;
  logic [15:0] dq_in, dq_out, fdq;
  int          n_errors = 0, num_checks = 0, cyc = 0;

  assign dq_in = dq_oe ? dq_out : fdq;
  fci_host dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .FL_ADDR(fl_addr), .FL_DQ_IN(dq_in), .FL_DQ_OUT(dq_out), .FL_DQ_OE(dq_oe), .FL_CE_N(ce_n),
    .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_RP_N(rp_n));
  fci_flash_model #(.ID_WORD(ID_WORD), .QRY_WORD(QRY_WORD)) flash (.clk(clk), .addr(fl_addr), .dq_in(dq_in),
    .dq_out(fdq), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n));

  // ==========================================================
  // Clock, timeout and verdict
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Bus tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      n_errors++;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic op(input fci_op_e o, input logic [21:0] a, input logic [15:0] d);
    ahb(1'b1, REG_ADDR, {10'h000, a});
    ahb(1'b1, REG_WDATA, {16'h0000, d});
    ahb(1'b1, REG_CTRL, {29'h0000_0000, o});
    do ahb(1'b0, REG_STATUS, 32'h0000_0000);
    while (r[ST_BUSY] !== 1'b0);
  endtask
  task automatic fr(input fci_op_e o, input string n, input logic [21:0] a, input logic [15:0] e);
    op(o, a, 16'h0000);
    ahb(1'b0, REG_RDATA, 32'h0000_0000);
    chk(n, r, {16'h0000, e});
  endtask
  task automatic sc(input string n, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(n, r & m, e);
  endtask

  // ==========================================================
  // Tests
  initial begin
    {rst_n, hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    op(OP_WRITE, 22'h00_0000, 16'h0090);
    fr(OP_READ, "ident", 22'h00_0000, ID_WORD);
    op(OP_WRITE, 22'h00_0000, 16'h0098);
    fr(OP_READ, "query", 22'h00_0010, QRY_WORD);
    $display("test modes done");
    op(OP_PROGRAM, 22'h00_0123, 16'h5A3C);
    fr(OP_READ, "prog busy", 22'h00_0000, 16'h0000);
    op(OP_POLL, 22'h00_0000, 16'h0000);
    fr(OP_READ, "prog status", 22'h3F_0000, 16'h0080);
    fr(OP_ARRAY_READ, "prog data", 22'h00_0123, 16'h5A3C);
    sc("array flag", 32'h0000_0002, 32'h0000_0002);
    op(OP_WRITE, 22'h00_0000, 16'h0010);
    op(OP_WRITE, 22'h00_0300, 16'h00F0);
    op(OP_POLL, 22'h00_0000, 16'h0000);
    fr(OP_ARRAY_READ, "alt prog", 22'h00_0300, 16'h00F0);
    $display("test program done");
    op(OP_WRITE, 22'h00_0000, 16'h0020);
    op(OP_WRITE, 22'h00_0000, 16'h1255);
    fr(OP_READ, "seq error", 22'h00_0000, 16'h00B0);
    op(OP_WRITE, 22'h00_0000, 16'hAB50);
    fr(OP_READ, "cleared", 22'h00_0000, 16'h0080);
    $display("test errors done");
    op(OP_PROGRAM, 22'h00_8010, 16'h0F0F);
    op(OP_POLL, 22'h00_0000, 16'h0000);
    op(OP_ERASE, 22'h00_8000, 16'h0000);
    op(OP_WRITE, 22'h00_0000, 16'h00FF);
    fr(OP_READ, "busy ignores", 22'h00_0000, 16'h0000);
    sc("busy array", 32'h0000_0002, 32'h0000_0000);
    op(OP_SUSPEND, 22'h00_0000, 16'h0000);
    sc("suspended", 32'h0000_000C, 32'h0000_000C);
    fr(OP_READ, "susp status", 22'h00_0000, 16'h00C0);
    op(OP_PROGRAM, 22'h00_0200, 16'h1234);
    op(OP_SUSPEND, 22'h00_0000, 16'h0000);
    fr(OP_READ, "prog suspended", 22'h00_0000, 16'h00C4);
    fr(OP_ARRAY_READ, "other read", 22'h00_0123, 16'h5A3C);
    op(OP_RESUME, 22'h00_0000, 16'h0000);
    sc("erase still susp", 32'h0000_000C, 32'h0000_000C);
    op(OP_POLL, 22'h00_0000, 16'h0000);
    fr(OP_ARRAY_READ, "nested prog", 22'h00_0200, 16'h1234);
    op(OP_ARRAY_READ, 22'h00_8010, 16'h0000);
    sc("refused", 32'h0000_0010, 32'h0000_0010);
    ahb(1'b1, REG_STATUS, 32'h0000_0010);
    op(OP_RESUME, 22'h00_0000, 16'h0000);
    sc("resumed", 32'h0000_001C, 32'h0000_0004);
    op(OP_POLL, 22'h00_0000, 16'h0000);
    fr(OP_ARRAY_READ, "erased", 22'h00_8010, 16'hFFFF);
    $display("test erase done");
    op(OP_WRITE, 22'h01_0000, 16'h0060);
    op(OP_WRITE, 22'h01_0000, 16'h002F);
    op(OP_WRITE, 22'h01_8000, 16'h0060);
    op(OP_WRITE, 22'h01_8000, 16'h0001);
    op(OP_WRITE, 22'h00_0000, 16'h0090);
    fr(OP_READ, "locked", 22'h01_8002, 16'h0001);
    for (int b = 2; b < 4; b++) begin
      op(OP_WRITE, 22'(b << 15), 16'h0060);
      op(OP_WRITE, 22'(b << 15), 16'h00D0);
    end
    op(OP_WRITE, 22'h00_0000, 16'h0090);
    fr(OP_READ, "lockdown kept", 22'h01_0002, 16'h0003);
    fr(OP_READ, "unlocked", 22'h01_8002, 16'h0000);
    $display("test locks done");
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", r, 32'h0000_0000);
    $display("test map done");
    close_out();
  end
endmodule
